// ### hdl/vpm_top.sv
// Voltage plausibility monitor with APB registers and interrupt
//
// Behaviour
// - Evaluate only with monitoring switched on; off by default, no alarm then.
// - Single-breaker mode, breaker_a closed: fault if side A and B flags differ.
// - Both sides okay and connected: phase outside window is a fault.
// - Dual mode, breaker_a closed: fault if side A and aux flags differ.
// - Dual mode, breaker_b closed: fault if side B and aux flags differ.
// - Dual mode, both closed: fault unless A, B and aux flags all agree.
// - Dual mode, both closed: A and B agree but phase out of window.
// - Alarm after fault persists for delay, 1 to 999 s, default 30 s.
// - On trip assert alarm output and mismatch display indication.
// - Alarm carries configurable class A to F or Control, default B.
// - Self-acknowledge yes: alarm clears once fault is gone.
// - Self-acknowledge no: alarm stays latched until manual or external acknowledge.
// - Enable mode always: evaluate continuously.
// - Enable mode lock: evaluate only while freeze input is false.
// - Enable mode user: evaluate only while selected user condition bit true.
`timescale 1ns/1ps
module vpm_top
  import vpm_pkg::*;
#(
  parameter int SEC_DIV = SEC_CYCLES,
  parameter int USER_BITS = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Plant inputs
  input wire logic breaker_a,
  input wire logic breaker_b,
  input wire logic side_a_voltage_ok_flag,
  input wire logic side_b_voltage_ok_flag,
  input wire logic aux_voltage_ok_flag,
  input wire logic phase_in_window,
  input wire logic monitor_freeze_input,
  input wire logic [USER_BITS-1:0] user_condition_bit_n,
  input wire logic ext_ack,
  // Alarm outputs
  output logic mismatch_alarm_output,
  output logic mismatch_display,
  output logic [2:0] alarm_class,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // Breaker contacts and acknowledge come from pins
  localparam int NSYNC = 8 + USER_BITS;
  logic [NSYNC-1:0] meta_ff;
  logic [NSYNC-1:0] sync_ff;
  logic cb_a, cb_b, ok_a, ok_b, ok_x, ph_ok, frz, ack_pin;
  logic [USER_BITS-1:0] ucond;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= {user_condition_bit_n, ext_ack, monitor_freeze_input, phase_in_window,
                  aux_voltage_ok_flag, side_b_voltage_ok_flag, side_a_voltage_ok_flag,
                  breaker_b, breaker_a};
      sync_ff <= meta_ff;
    end
  end

  assign cb_a = sync_ff[0];
  assign cb_b = sync_ff[1];
  assign ok_a = sync_ff[2];
  assign ok_b = sync_ff[3];
  assign ok_x = sync_ff[4];
  assign ph_ok = sync_ff[5];
  assign frz = sync_ff[6];
  assign ack_pin = sync_ff[7];
  assign ucond = sync_ff[NSYNC-1:8];

  ////////////////////////////////////////////////////////////////////////////
  // APB register file
  logic mon_on_ff, self_ack_ff, dual_ff;
  logic [1:0] en_mode_ff;
  logic [2:0] class_ff;
  logic [9:0] delay_ff;
  logic [4:0] usr_sel_ff;
  logic [IRQ_W-1:0] int_stat_ff, int_mask_ff;
  logic [31:0] rd_mux;
  logic acc, wr, rd;
  logic sel_ctrl, sel_delay, sel_usr, sel_stat, sel_istat, sel_imask, sel_ack, mapped;
  logic alarm_ff, fault;
  logic [9:0] secs_ff;
  logic [9:0] wr_delay;
  logic sw_ack;
  logic [IRQ_W-1:0] irq_evt;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign sel_ctrl = (paddr == CTRL_OFS);
  assign sel_delay = (paddr == DELAY_OFS);
  assign sel_usr = (paddr == USRSEL_OFS);
  assign sel_stat = (paddr == STATUS_OFS);
  assign sel_istat = (paddr == INT_STAT_OFS);
  assign sel_imask = (paddr == INT_MASK_OFS);
  assign sel_ack = (paddr == ACK_OFS);
  assign mapped = sel_ctrl | sel_delay | sel_usr | sel_stat | sel_istat | sel_imask | sel_ack;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  // Out-of-range delay writes are clamped so the timer never sees zero
  assign wr_delay = (pwdata[9:0] < DELAY_MIN_S) ? DELAY_MIN_S :
                    (pwdata[9:0] > DELAY_MAX_S) ? DELAY_MAX_S : pwdata[9:0];
  assign sw_ack = wr && sel_ack && pwdata[0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mon_on_ff <= 1'b0;
      self_ack_ff <= 1'b0;
      dual_ff <= 1'b0;
      en_mode_ff <= EN_ALWAYS;
      class_ff <= CLASS_B;
      delay_ff <= DELAY_RST_S;
      usr_sel_ff <= 5'h00;
      int_mask_ff <= '0;
    end
    else if (wr)
    begin
      if (sel_ctrl)
      begin
        mon_on_ff <= pwdata[CTRL_MON_BIT];
        self_ack_ff <= pwdata[CTRL_SELFACK_BIT];
        dual_ff <= pwdata[CTRL_DUAL_BIT];
        en_mode_ff <= (pwdata[CTRL_EN_LSB +: 2] > EN_USER) ? EN_ALWAYS : pwdata[CTRL_EN_LSB +: 2];
        class_ff <= (pwdata[CTRL_CLASS_LSB +: 3] > CLASS_CTRL) ? CLASS_CTRL :
                    pwdata[CTRL_CLASS_LSB +: 3];
      end
      if (sel_delay)
        delay_ff <= wr_delay;
      if (sel_usr)
        usr_sel_ff <= pwdata[4:0];
      if (sel_imask)
        int_mask_ff <= pwdata[IRQ_W-1:0];
    end
  end

  assign rd_mux = sel_ctrl ? {21'h0, class_ff, 2'h0, en_mode_ff, 1'b0, dual_ff, self_ack_ff,
                              mon_on_ff} :
                  sel_delay ? {22'h0, delay_ff} :
                  sel_usr ? {27'h0, usr_sel_ff} :
                  sel_stat ? {8'h0, secs_ff, 6'h0, ph_ok, ok_x, ok_b, ok_a, cb_b, cb_a,
                              fault, alarm_ff} :
                  sel_istat ? {30'h0, int_stat_ff} :
                  sel_imask ? {30'h0, int_mask_ff} : 32'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault evaluation
  logic connected_ab, fault_single, fault_dual, evaluate, usr_bit;

  assign usr_bit = ucond[usr_sel_ff];
  // always, lock, user bit; master switch
  assign evaluate = mon_on_ff &&
                    ((en_mode_ff == EN_ALWAYS) ||
                     ((en_mode_ff == EN_LOCK) && !frz) ||
                     ((en_mode_ff == EN_USER) && usr_bit));
  // single mode, A and B flags
  // both okay and connected, phase window
  assign fault_single = cb_a && ((ok_a != ok_b) || (ok_a && ok_b && !ph_ok));
  // A vs aux, B vs aux
  // three-way agreement; phase check with both closed
  assign connected_ab = cb_a && cb_b;
  assign fault_dual = (cb_a && (ok_a != ok_x)) ||
                      (cb_b && (ok_b != ok_x)) ||
                      (connected_ab && !((ok_a == ok_b) && (ok_b == ok_x))) ||
                      (connected_ab && (ok_a == ok_b) && !ph_ok);
  assign fault = evaluate && (dual_ff ? fault_dual : fault_single);

  ////////////////////////////////////////////////////////////////////////////
  // Delay timer and alarm latch
  logic sec_tick, expire;
  logic [9:0] nxt_secs;
  logic nxt_alarm;

  // Timer runs only while the fault stands, so each fault starts a fresh second
  vpm_tick #(
    .DIV(SEC_DIV)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .run(fault && !alarm_ff),
    .tick(sec_tick)
  );

  assign expire = sec_tick && (secs_ff + 10'h1 >= delay_ff);
  // restart on clear, cleared while not evaluating
  assign nxt_secs = (!fault || alarm_ff) ? 10'h0 : (sec_tick ? secs_ff + 10'h1 : secs_ff);

  // latched until self, manual or external acknowledge
  // switching monitoring off drops the alarm
  assign nxt_alarm = !mon_on_ff ? 1'b0 :
                     expire ? 1'b1 :
                     (alarm_ff && self_ack_ff && !fault) ? 1'b0 :
                     (alarm_ff && (sw_ack || ack_pin) && !fault) ? 1'b0 : alarm_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      secs_ff <= 10'h0;
      alarm_ff <= 1'b0;
    end
    else
    begin
      secs_ff <= nxt_secs;
      alarm_ff <= nxt_alarm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, set wins over write-one-to-clear
  assign irq_evt = {alarm_ff && !nxt_alarm, !alarm_ff && nxt_alarm};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_stat_ff <= '0;
    else
      int_stat_ff <= irq_evt | (int_stat_ff &
                     ~((wr && sel_istat) ? pwdata[IRQ_W-1:0] : {IRQ_W{1'b0}}));
  end

  assign irq = |(int_stat_ff & int_mask_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // alarm output and display indication
  assign mismatch_alarm_output = alarm_ff;
  assign mismatch_display = alarm_ff;
  assign alarm_class = class_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_mon_off_quiet: assert property (!mon_on_ff |=> !alarm_ff)
    else $error("alarm while monitoring off");
  a_trip_needs_fault: assert property ($rose(alarm_ff) |-> $past(fault))
    else $error("alarm rose without fault");
  a_timer_reset: assert property (!fault |=> secs_ff == 10'h0)
    else $error("timer not cleared");
  a_latch_hold: assert property (alarm_ff && !self_ack_ff && !sw_ack && !ack_pin && mon_on_ff
                                 |=> alarm_ff)
    else $error("latched alarm dropped without ack");
  a_self_ack: assert property (alarm_ff && self_ack_ff && !fault && mon_on_ff
                               |=> !alarm_ff)
    else $error("self ack did not clear");
  a_lock_mode: assert property (en_mode_ff == EN_LOCK && frz |-> !fault)
    else $error("evaluation during lock");
  a_user_mode: assert property (en_mode_ff == EN_USER && !usr_bit |-> !fault)
    else $error("evaluation without user bit");
  a_single_ab: assert property (mon_on_ff && en_mode_ff == EN_ALWAYS && !dual_ff && cb_a
                                && ok_a != ok_b |-> fault)
    else $error("single mode mismatch missed");
  a_dual_aux: assert property (mon_on_ff && en_mode_ff == EN_ALWAYS && dual_ff && cb_b
                               && ok_b != ok_x |-> fault)
    else $error("dual mode aux mismatch missed");

  // Fault decode by mode
  a_single_phase: assert property (mon_on_ff && en_mode_ff == EN_ALWAYS && !dual_ff && cb_a
                                   && ok_a && ok_b && !ph_ok |-> fault)
    else $error("single mode phase fault missed");
  a_single_open: assert property (!dual_ff && !cb_a |-> !fault)
    else $error("single mode fault with breaker open");
  a_dual_side_a: assert property (mon_on_ff && en_mode_ff == EN_ALWAYS && dual_ff && cb_a
                                  && ok_a != ok_x |-> fault)
    else $error("dual mode side a mismatch missed");
  a_dual_three: assert property (mon_on_ff && dual_ff && en_mode_ff == EN_ALWAYS
                                 && connected_ab && !(ok_a == ok_b && ok_b == ok_x) |-> fault)
    else $error("three way mismatch missed");
  a_dual_phase: assert property (mon_on_ff && dual_ff && en_mode_ff == EN_ALWAYS
                                 && connected_ab && ok_a == ok_b && !ph_ok |-> fault)
    else $error("dual mode phase fault missed");
  a_off_no_fault: assert property (!mon_on_ff |-> !fault)
    else $error("fault evaluated while monitoring off");
  a_lock_free: assert property (mon_on_ff && en_mode_ff == EN_LOCK && !frz && !dual_ff
                                && cb_a && ok_a != ok_b |-> fault)
    else $error("lock mode missed fault while free");
  a_user_set: assert property (mon_on_ff && en_mode_ff == EN_USER && usr_bit && !dual_ff
                               && cb_a && ok_a != ok_b |-> fault)
    else $error("user mode missed fault with bit set");

  // Timer and latch
  a_trip_on_tick: assert property ($rose(alarm_ff) |-> $past(sec_tick))
    else $error("alarm rose without second tick");
  a_timer_step: assert property (fault && !alarm_ff && sec_tick
                                 |=> secs_ff == $past(secs_ff) + 10'h1)
    else $error("timer did not advance");
  a_timer_idle: assert property (alarm_ff |=> secs_ff == 10'h0)
    else $error("timer ran while alarm set");
  a_ack_refused: assert property (alarm_ff && fault && mon_on_ff |=> alarm_ff)
    else $error("alarm dropped while fault present");
  a_ext_ack: assert property (alarm_ff && ack_pin && !fault && mon_on_ff |=> !alarm_ff)
    else $error("external acknowledge ignored");

  // Register and interrupt
  a_irq_on_trip: assert property ($rose(alarm_ff) |-> int_stat_ff[IRQ_TRIP_BIT])
    else $error("trip event not recorded");
  a_class_out: assert property (wr && sel_ctrl && pwdata[CTRL_CLASS_LSB +: 3] <= CLASS_CTRL
                                |=> alarm_class == $past(pwdata[CTRL_CLASS_LSB +: 3]))
    else $error("alarm class not as written");

  c_trip: cover property ($rose(alarm_ff));
  c_self_clear: cover property (self_ack_ff && $fell(alarm_ff));
  c_ext_ack: cover property (ack_pin && $fell(alarm_ff));
  c_dual_fault: cover property (dual_ff && connected_ab && fault);
  c_lock_block: cover property (mon_on_ff && en_mode_ff == EN_LOCK && frz);

endmodule

// ### hdl/vpm_pkg.sv
// Package: register map, field layouts and timing constants of the voltage plausibility monitor
package vpm_pkg;

  // Bus
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DELAY_OFS = 8'h04;
  localparam logic [7:0] USRSEL_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] INT_STAT_OFS = 8'h10;
  localparam logic [7:0] INT_MASK_OFS = 8'h14;
  localparam logic [7:0] ACK_OFS = 8'h18;

  // Control fields
  localparam int CTRL_MON_BIT = 0;
  localparam int CTRL_SELFACK_BIT = 1;
  localparam int CTRL_DUAL_BIT = 2;
  localparam int CTRL_EN_LSB = 4;
  localparam int CTRL_CLASS_LSB = 8;

  // Enable modes
  localparam logic [1:0] EN_ALWAYS = 2'h0;
  localparam logic [1:0] EN_LOCK = 2'h1;
  localparam logic [1:0] EN_USER = 2'h2;

  // Alarm classes A..F, Control
  localparam logic [2:0] CLASS_A = 3'h0;
  localparam logic [2:0] CLASS_B = 3'h1;
  localparam logic [2:0] CLASS_CTRL = 3'h6;

  // Delay setting in seconds
  localparam logic [9:0] DELAY_MIN_S = 10'h001;
  localparam logic [9:0] DELAY_MAX_S = 10'h3e7;
  localparam logic [9:0] DELAY_RST_S = 10'h01e;

  // Timing
  localparam int CLK_HZ = 40000000;
  localparam int SEC_CYCLES = CLK_HZ;

  // Interrupt status bits
  localparam int IRQ_TRIP_BIT = 0;
  localparam int IRQ_CLEAR_BIT = 1;
  localparam int IRQ_W = 2;

endpackage

// ### hdl/vpm_tick.sv
// One-cycle enable pulse divider
`timescale 1ns/1ps
module vpm_tick #(
  parameter int DIV = 40000000
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic run,
  output logic tick
);

  logic [31:0] cnt_ff;
  logic last;

  assign last = (cnt_ff == 32'(DIV - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_ff <= 32'h0;
    else if (!run || last)
      cnt_ff <= 32'h0;
    else
      cnt_ff <= cnt_ff + 32'h1;
  end

  assign tick = run && last;

endmodule

// ### dv/vpm_plant.sv
// Plant model: breaker feedbacks and voltage front end lines
`timescale 1ns/1ps
module vpm_plant (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requested plant state
  input wire logic [7:0] want,
  input wire logic [31:0] want_usr,
  // Lines into the monitor
  output logic monitor_freeze_input,
  output logic breaker_a,
  output logic breaker_b,
  output logic side_a_voltage_ok_flag,
  output logic side_b_voltage_ok_flag,
  output logic aux_voltage_ok_flag,
  output logic phase_in_window,
  output logic [31:0] user_condition_bit_n
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {monitor_freeze_input, breaker_a, breaker_b} <= 3'h0;
      {side_a_voltage_ok_flag, side_b_voltage_ok_flag} <= 2'h0;
      {aux_voltage_ok_flag, phase_in_window} <= 2'h0;
      user_condition_bit_n <= 32'h0;
    end
    else
    begin
      {monitor_freeze_input, breaker_a, breaker_b} <= {want[7], want[5:4]};
      {side_a_voltage_ok_flag, side_b_voltage_ok_flag} <= want[3:2];
      {aux_voltage_ok_flag, phase_in_window} <= want[1:0];
      user_condition_bit_n <= want_usr;
    end
  end
endmodule

// ### dv/voltage_plausibility_monitor_test.sv
// Self-checking bench of the voltage plausibility monitor
`timescale 1ns/1ps
module voltage_plausibility_monitor_test import vpm_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic ext_ack = 1'b0, serr;
  logic [7:0] paddr = 8'h00, want = 8'h00;
  logic [31:0] pwdata = 32'h0, usr = 32'h0, rd, prdata;
  logic pready, pslverr, frz, cba, cbb, oka, okb, okx, ph, alarm, disp, irq;
  logic [31:0] ubits;
  logic [2:0] aclass;
  int err_count = 0;
  int n_tests = 0;
  // Table rows: expected alarm, control word, plant state {frz,user,a,b,oka,okb,okx,ph}
  localparam logic [19:0] TBL [15] = '{20'h0_00_29, 20'h1_01_29, 20'h0_01_23, 20'h1_01_2c,
    20'h0_01_19, 20'h1_05_29, 20'h0_05_2b, 20'h1_05_15, 20'h1_05_3d, 20'h1_05_3e,
    20'h0_05_3f, 20'h0_11_a9, 20'h1_11_29, 20'h0_21_29, 20'h1_21_69};

  always #12.5 pclk = ~pclk;

  vpm_top #(.SEC_DIV(10), .USER_BITS(32)) u_vpm_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .breaker_a(cba), .breaker_b(cbb),
    .side_a_voltage_ok_flag(oka), .side_b_voltage_ok_flag(okb), .aux_voltage_ok_flag(okx),
    .phase_in_window(ph), .monitor_freeze_input(frz), .user_condition_bit_n(ubits),
    .ext_ack(ext_ack), .mismatch_alarm_output(alarm), .mismatch_display(disp),
    .alarm_class(aclass), .irq(irq));

  vpm_plant u_vpm_plant (.pclk(pclk), .presetn(presetn), .want(want), .want_usr(usr),
    .monitor_freeze_input(frz), .breaker_a(cba), .breaker_b(cbb),
    .side_a_voltage_ok_flag(oka), .side_b_voltage_ok_flag(okb), .aux_voltage_ok_flag(okx),
    .phase_in_window(ph), .user_condition_bit_n(ubits));

  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t %s: got %h exp %h", $time, m, seen, exp);
    end
  endtask

  // Bus cycle; waits on pready rather than trusting zero wait states
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    serr = pslverr;
    {psel, penable} <= 2'h0;
  endtask

  task plant(input logic [7:0] p);
    @(posedge pclk);
    want <= p;
    usr <= p[6] ? 32'h20 : 32'hffffffdf;
  endtask

  task end_sim;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task t_regs;
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'h100, "ctrl reset");
    chk({29'h0, aclass}, 32'h1, "class reset");
    apb(1'b0, DELAY_OFS, 32'h0);
    chk(rd, 32'h1e, "delay reset");
    apb(1'b1, DELAY_OFS, 32'h0);
    apb(1'b0, DELAY_OFS, 32'h0);
    chk(rd, 32'h1, "delay min");
    apb(1'b1, DELAY_OFS, 32'h3ff);
    apb(1'b0, DELAY_OFS, 32'h0);
    chk(rd, 32'h3e7, "delay max");
    apb(1'b1, CTRL_OFS, 32'h700);
    @(posedge pclk);
    chk({29'h0, aclass}, 32'h6, "class ctrl");
    apb(1'b1, CTRL_OFS, 32'h300);
    @(posedge pclk);
    chk({29'h0, aclass}, 32'h3, "class d");
    apb(1'b0, 8'h1c, 32'h0);
    chk({31'h0, serr}, 32'h1, "unmapped");
    apb(1'b1, DELAY_OFS, 32'h1);
    apb(1'b1, USRSEL_OFS, 32'h5);
  endtask

  task t_table;
    for (int i = 0; i < 15; i++)
    begin
      apb(1'b1, CTRL_OFS, {24'h0, TBL[i][15:8]});
      plant(TBL[i][7:0]);
      repeat (20) @(posedge pclk);
      chk({31'h0, alarm}, {31'h0, TBL[i][16]}, "table alarm");
      chk({31'h0, disp}, {31'h0, TBL[i][16]}, "table display");
      apb(1'b1, CTRL_OFS, 32'h0);
      plant(8'h00);
      repeat (4) @(posedge pclk);
    end
  endtask

  task t_latch;
    apb(1'b1, INT_STAT_OFS, 32'h3);
    apb(1'b1, INT_MASK_OFS, 32'h1);
    apb(1'b1, CTRL_OFS, 32'h1);
    plant(8'h29);
    repeat (7) @(posedge pclk);
    plant(8'h2d);
    repeat (1) @(posedge pclk);
    plant(8'h29);
    repeat (9) @(posedge pclk);
    chk({30'h0, alarm, irq}, 32'h0, "timer restart");
    repeat (9) @(posedge pclk);
    chk({29'h0, alarm, disp, irq}, 32'h7, "trip");
    apb(1'b0, STATUS_OFS, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h3, "status alarm");
    apb(1'b1, ACK_OFS, 32'h1);
    @(posedge pclk);
    chk({31'h0, alarm}, 32'h1, "ack in fault");
    plant(8'h2d);
    repeat (6) @(posedge pclk);
    chk({31'h0, alarm}, 32'h1, "latched");
    ext_ack <= 1'b1;
    repeat (4) @(posedge pclk);
    ext_ack <= 1'b0;
    chk({31'h0, alarm}, 32'h0, "ext ack");
    apb(1'b0, INT_STAT_OFS, 32'h0);
    chk(rd, 32'h3, "trip and clear events");
    plant(8'h29);
    repeat (20) @(posedge pclk);
    plant(8'h2d);
    repeat (4) @(posedge pclk);
    apb(1'b1, ACK_OFS, 32'h1);
    @(posedge pclk);
    chk({31'h0, alarm}, 32'h0, "manual ack");
    apb(1'b1, INT_STAT_OFS, 32'h3);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0, "irq clear");
  endtask

  task t_self;
    apb(1'b1, CTRL_OFS, 32'h3);
    plant(8'h29);
    repeat (20) @(posedge pclk);
    chk({31'h0, alarm}, 32'h1, "self trip");
    plant(8'h2d);
    repeat (6) @(posedge pclk);
    chk({31'h0, alarm}, 32'h0, "self clear");
    apb(1'b1, CTRL_OFS, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_table;
    t_latch;
    t_self;
    end_sim;
  end

  // Run needs about 650 cycles; allow ample margin
  initial
  begin
    #(5000 * 25);
    err_count++;
    end_sim;
  end
endmodule
